/* hdl/slptg_pkg.sv */
// constants, types and helper functions of the serial link test pattern generator
// Notes on behaviour
// R1: four-bit selector: off, checkerboard, word toggle; writing off here keeps a running test, only soft reset ends it
// R2: two-bit injection field picks pattern entry point
// R3: soft reset 0x81 at address zero, self cleared
// R4: transport sample test sends raw converter samples
// R5: codes three to seven select PN sequences
// R6: ramp counts per word, width follows injection
// R7: repeat mode cycles four user patterns forever
// R8: single mode sends four patterns then zeros
// R9: user patterns come from eight configuration bytes
// R10: sample input: both samples equal, per frame
// R11: ten-bit input: per symbol, user bits high ten
// R12: eight-bit input: per octet, user bits fifteen-nine
// R13: three-bit field selects link layer test sequences
// R14: software masks sync request during link tests
// R15: stages before injection point bypassed during test
package slptg_pkg;

   // ==========================================================
   // register map
   localparam logic [11:0] SLPTG_ADDR_SOFT_RST = 12'h0000;
   localparam logic [11:0] SLPTG_ADDR_TPL_TEST = 12'h0571;
   localparam logic [11:0] SLPTG_ADDR_SYNC_CTL = 12'h0572;
   localparam logic [11:0] SLPTG_ADDR_ITS_SEL  = 12'h0573;
   localparam logic [11:0] SLPTG_ADDR_DLL_SEL  = 12'h0574;
   localparam logic [11:0] SLPTG_ADDR_UP_FIRST = 12'h0551;
   localparam logic [11:0] SLPTG_ADDR_UP_LAST  = 12'h0558;
   localparam logic [7:0]  SLPTG_REG_RESET     = 8'h00;
   localparam logic [7:0]  SLPTG_SOFT_RST_MASK = 8'h81;

   // ==========================================================
   // field positions
   localparam int SLPTG_ITS_CODE_LSB  = 0;
   localparam int SLPTG_ITS_INJ_LSB   = 4;
   localparam int SLPTG_TPL_TEST_BIT  = 5;
   localparam int SLPTG_SYNC_IGN_LSB  = 6;
   localparam logic [1:0] SLPTG_SYNC_IGN_VAL = 2'h3;

   // ==========================================================
   // interface test codes and injection points
   localparam logic [3:0] SLPTG_CODE_OFF      = 4'h0;
   localparam logic [3:0] SLPTG_CODE_CHECKER  = 4'h1;
   localparam logic [3:0] SLPTG_CODE_TOGGLE   = 4'h2;
   localparam logic [3:0] SLPTG_CODE_PN_FIRST = 4'h3;
   localparam logic [3:0] SLPTG_CODE_PN_LAST  = 4'h7;
   localparam logic [3:0] SLPTG_CODE_RAMP     = 4'h8;
   localparam logic [3:0] SLPTG_CODE_USER_REP = 4'hE;
   localparam logic [3:0] SLPTG_CODE_USER_ONE = 4'hF;
   localparam logic [1:0] SLPTG_INJ_TPL       = 2'h0;
   localparam logic [1:0] SLPTG_INJ_PHY       = 2'h1;
   localparam logic [1:0] SLPTG_INJ_SCR       = 2'h2;

   // ==========================================================
   // pattern words and unit widths
   localparam logic [15:0] SLPTG_CHECK_A  = 16'h5555;
   localparam logic [15:0] SLPTG_CHECK_B  = 16'hAAAA;
   localparam logic [15:0] SLPTG_ZERO_W   = 16'h0000;
   localparam logic [15:0] SLPTG_ONES_W   = 16'hFFFF;
   localparam logic [4:0]  SLPTG_W_TPL    = 5'h10;
   localparam logic [4:0]  SLPTG_W_PHY    = 5'h0A;
   localparam logic [4:0]  SLPTG_W_SCR    = 5'h08;
   localparam int          SLPTG_NUM_PN   = 5;
   localparam int          SLPTG_NUM_UP   = 8;

   // ==========================================================
   // PN polynomials (length, second tap) and seeds, in code order
   localparam int SLPTG_PN_LEN [0:4] = '{31, 23, 15, 9, 7};
   localparam int SLPTG_PN_TAP [0:4] = '{28, 18, 14, 5, 6};
   localparam logic [30:0] SLPTG_PN_SEED [0:4] = '{31'h0003_AFFF, 31'h0000_3AFF, 31'h0000_03AF,
                                                  31'h0000_0092, 31'h0000_0007};

   // user pattern sequencer
   typedef enum {SLPTG_US_P1, SLPTG_US_P2, SLPTG_US_P3, SLPTG_US_P4, SLPTG_US_DONE} slptg_user_t;

   // code belongs to the PN group
   function automatic logic slptg_is_pn(input logic [3:0] code);
      return (code >= SLPTG_CODE_PN_FIRST) && (code <= SLPTG_CODE_PN_LAST);
   endfunction

   // code belongs to the user pattern group
   function automatic logic slptg_is_user(input logic [3:0] code);
      return (code == SLPTG_CODE_USER_REP) || (code == SLPTG_CODE_USER_ONE);
   endfunction

endpackage

/* hdl/slptg_pn.sv */
// one PN generator: two-tap Fibonacci LFSR stepping a variable number of bits per unit
`timescale 1ns/10ps
`default_nettype none
module slptg_pn #(
   parameter int          LEN  = 9,
   parameter int          TAP  = 5,
   parameter logic [30:0] SEED = 31'h0000_0092
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   input  wire logic        load_in,
   input  wire logic        adv_in,
   input  wire logic [4:0]  nbits_in,
   output logic      [15:0] word_out
);
   logic [LEN-1:0] state_q;
   logic [LEN-1:0] state_d;

   // first bit of the unit lands in the word's msb; the seed's lsb leaves first
   always_comb begin
      logic [LEN-1:0] s;
      s = state_q;
      word_out = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if (i < int'(nbits_in)) begin
            word_out[15-i] = s[0];
            s = {s[0] ^ s[LEN-TAP], s[LEN-1:1]};
         end
      end
      state_d = s;
   end

   // seed on restart, advance one unit per strobe
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= SEED[LEN-1:0];
      end else if (load_in) begin
         state_q <= SEED[LEN-1:0];
      end else if (adv_in) begin
         state_q <= state_d;
      end
   end
endmodule
`default_nettype wire

/* hdl/slptg_top.sv */
// test pattern generator of the serial link transmit path, with its control registers
`timescale 1ns/10ps
`default_nettype none
module slptg_top (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // register port
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [11:0] reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   output logic             reg_rvalid_out,
   // data path
   input  wire logic [15:0] sample_in,
   input  wire logic        unit_adv_in,
   input  wire logic        link_sync_request_input_in,
   output logic      [15:0] tpl_data_out,
   output logic             tpl_sel_out,
   output logic      [9:0]  phy_data_out,
   output logic             phy_sel_out,
   output logic      [7:0]  scr_data_out,
   output logic             scr_sel_out,
   output logic             pre_bypass_out,
   output logic      [2:0]  dll_test_sel_out,
   output logic             link_sync_request_out
);
   import slptg_pkg::*;

   // ==========================================================
   // register state
   logic [7:0]  soft_reset_config_q;
   logic [7:0]  transport_sample_test_ctrl_q;
   logic [7:0]  link_sync_input_ctrl_q;
   logic [7:0]  interface_test_select_q;
   logic [7:0]  link_layer_test_select_q;
   logic [7:0]  user_byte_q [0:SLPTG_NUM_UP-1];
   logic [3:0]  eff_code_q;
   logic        restart_q;

   // ==========================================================
   // register decode
   wire         wr_soft   = reg_wr_in && (reg_addr_in == SLPTG_ADDR_SOFT_RST);
   wire         soft_rst  = wr_soft && ((reg_wdata_in & SLPTG_SOFT_RST_MASK) == SLPTG_SOFT_RST_MASK); // R3
   wire         wr_tpl    = reg_wr_in && (reg_addr_in == SLPTG_ADDR_TPL_TEST);
   wire         wr_sync   = reg_wr_in && (reg_addr_in == SLPTG_ADDR_SYNC_CTL);
   wire         wr_its    = reg_wr_in && (reg_addr_in == SLPTG_ADDR_ITS_SEL);
   wire         wr_dll    = reg_wr_in && (reg_addr_in == SLPTG_ADDR_DLL_SEL);
   wire         in_up     = (reg_addr_in >= SLPTG_ADDR_UP_FIRST) && (reg_addr_in <= SLPTG_ADDR_UP_LAST);
   wire  [11:0] up_off    = reg_addr_in - SLPTG_ADDR_UP_FIRST;
   wire  [2:0]  up_idx    = up_off[2:0];
   wire  [3:0]  wr_code   = reg_wdata_in[SLPTG_ITS_CODE_LSB +: 4];
   wire  [1:0]  inj       = interface_test_select_q[SLPTG_ITS_INJ_LSB +: 2]; // R2
   wire         tpl_test  = transport_sample_test_ctrl_q[SLPTG_TPL_TEST_BIT];

   // read data selection, unmapped addresses read zero
   wire  [7:0]  rd_mux =
      (reg_addr_in == SLPTG_ADDR_SOFT_RST) ? soft_reset_config_q :
      (reg_addr_in == SLPTG_ADDR_TPL_TEST) ? transport_sample_test_ctrl_q :
      (reg_addr_in == SLPTG_ADDR_SYNC_CTL) ? link_sync_input_ctrl_q :
      (reg_addr_in == SLPTG_ADDR_ITS_SEL)  ? interface_test_select_q :
      (reg_addr_in == SLPTG_ADDR_DLL_SEL)  ? link_layer_test_select_q :
      in_up                                ? user_byte_q[up_idx] :
                                             SLPTG_REG_RESET;

   // control registers; soft reset returns all to defaults
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         soft_reset_config_q          <= SLPTG_REG_RESET;
         transport_sample_test_ctrl_q <= SLPTG_REG_RESET;
         link_sync_input_ctrl_q       <= SLPTG_REG_RESET;
         interface_test_select_q      <= SLPTG_REG_RESET;
         link_layer_test_select_q     <= SLPTG_REG_RESET;
      end else if (soft_rst) begin
         soft_reset_config_q          <= SLPTG_REG_RESET; // R3
         transport_sample_test_ctrl_q <= SLPTG_REG_RESET;
         link_sync_input_ctrl_q       <= SLPTG_REG_RESET;
         interface_test_select_q      <= SLPTG_REG_RESET;
         link_layer_test_select_q     <= SLPTG_REG_RESET;
      end else begin
         if (wr_soft) soft_reset_config_q <= reg_wdata_in & ~SLPTG_SOFT_RST_MASK;
         if (wr_tpl)  transport_sample_test_ctrl_q <= reg_wdata_in;
         if (wr_sync) link_sync_input_ctrl_q <= reg_wdata_in;
         if (wr_its)  interface_test_select_q <= reg_wdata_in;
         if (wr_dll)  link_layer_test_select_q <= reg_wdata_in;
      end
   end

   // user pattern bytes, low byte at the even offset from the first address
   genvar g;
   generate
      for (g = 0; g < SLPTG_NUM_UP; g++) begin : g_up
         always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               user_byte_q[g] <= SLPTG_REG_RESET;
            end else if (soft_rst) begin
               user_byte_q[g] <= SLPTG_REG_RESET;
            end else if (reg_wr_in && in_up && (up_idx == 3'(g))) begin
               user_byte_q[g] <= reg_wdata_in; // R9
            end
         end
      end
   endgenerate

   // running code: a zero code does not end a test, only a soft reset does
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         eff_code_q <= SLPTG_CODE_OFF;
         restart_q  <= 1'b0;
      end else begin
         restart_q <= wr_its || soft_rst;
         if (soft_rst) begin
            eff_code_q <= SLPTG_CODE_OFF; // R3
         end else if (wr_its && (wr_code != SLPTG_CODE_OFF)) begin
            eff_code_q <= wr_code; // R1
         end
      end
   end

   // ==========================================================
   // pattern state
   wire         active   = (eff_code_q != SLPTG_CODE_OFF);
   wire         adv      = active && unit_adv_in && !restart_q;
   wire  [4:0]  nbits    = (inj == SLPTG_INJ_PHY) ? SLPTG_W_PHY :
                           (inj == SLPTG_INJ_SCR) ? SLPTG_W_SCR : SLPTG_W_TPL;
   wire  [3:0]  pn_off   = eff_code_q - SLPTG_CODE_PN_FIRST;
   wire  [2:0]  pn_idx   = pn_off[2:0];
   wire  [15:0] pn_word [0:SLPTG_NUM_PN-1];
   logic        phase_q;
   logic [15:0] ramp_q;
   slptg_user_t user_q;
   slptg_user_t user_d;

   // one PN generator per polynomial, only the selected one advances
   generate
      for (g = 0; g < SLPTG_NUM_PN; g++) begin : g_pn
         slptg_pn #(
            .LEN  (SLPTG_PN_LEN[g]),
            .TAP  (SLPTG_PN_TAP[g]),
            .SEED (SLPTG_PN_SEED[g])
         ) u_pn (
            .clk_sys_in (clk_sys_in),
            .rst_n_in   (rst_n_in),
            .load_in    (restart_q),
            .adv_in     (adv && slptg_is_pn(eff_code_q) && (pn_idx == 3'(g))), // R5
            .nbits_in   (nbits),
            .word_out   (pn_word[g])
         );
      end
   endgenerate

   // user sequencer: repeat wraps to the first, single parks on zeros
   always_comb begin
      case (user_q)
         SLPTG_US_P1:   user_d = SLPTG_US_P2;
         SLPTG_US_P2:   user_d = SLPTG_US_P3;
         SLPTG_US_P3:   user_d = SLPTG_US_P4;
         SLPTG_US_P4:   user_d = (eff_code_q == SLPTG_CODE_USER_ONE) ? SLPTG_US_DONE : SLPTG_US_P1; // R7 R8
         SLPTG_US_DONE: user_d = SLPTG_US_DONE; // R8
         default:       user_d = SLPTG_US_P1;
      endcase
   end

   // unit counters step once per frame, symbol or octet
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_q <= 1'b0;
         ramp_q  <= SLPTG_ZERO_W;
         user_q  <= SLPTG_US_P1;
      end else if (restart_q) begin
         phase_q <= 1'b0;
         ramp_q  <= SLPTG_ZERO_W;
         user_q  <= SLPTG_US_P1;
      end else if (adv) begin
         phase_q <= ~phase_q; // R10 R11 R12
         ramp_q  <= ramp_q + 16'h0001; // R6
         user_q  <= user_d;
      end
   end

   // ==========================================================
   // pattern word selection
   wire  [15:0] user_word =
      (user_q == SLPTG_US_P1) ? {user_byte_q[1], user_byte_q[0]} :
      (user_q == SLPTG_US_P2) ? {user_byte_q[3], user_byte_q[2]} :
      (user_q == SLPTG_US_P3) ? {user_byte_q[5], user_byte_q[4]} :
      (user_q == SLPTG_US_P4) ? {user_byte_q[7], user_byte_q[6]} : SLPTG_ZERO_W; // R9
   wire         is_ramp  = (eff_code_q == SLPTG_CODE_RAMP);
   wire         is_user  = slptg_is_user(eff_code_q);
   wire  [15:0] pat_word =
      (eff_code_q == SLPTG_CODE_CHECKER) ? (phase_q ? SLPTG_CHECK_B : SLPTG_CHECK_A) : // R1
      (eff_code_q == SLPTG_CODE_TOGGLE)  ? (phase_q ? SLPTG_ONES_W : SLPTG_ZERO_W) :   // R1
      slptg_is_pn(eff_code_q)            ? pn_word[pn_idx] :                            // R5
      is_ramp                            ? ramp_q :                                     // R6
      is_user                            ? user_word : SLPTG_ZERO_W;

   // per injection point formatting
   wire  [9:0]  phy_pat  = is_ramp ? ramp_q[9:0] : pat_word[15:6]; // R11
   wire  [7:0]  scr_pat  = is_ramp ? ramp_q[7:0] :
                           is_user ? {1'b0, pat_word[15:9]} : pat_word[15:8]; // R12
   wire         tpl_pat  = active && (inj == SLPTG_INJ_TPL);
   wire         phy_pat_on = active && (inj == SLPTG_INJ_PHY);
   wire         scr_pat_on = active && (inj == SLPTG_INJ_SCR);
   wire  [15:0] tpl_d    = tpl_pat ? pat_word : sample_in; // R10 R4
   wire         sync_ign = (link_sync_input_ctrl_q[SLPTG_SYNC_IGN_LSB +: 2] == SLPTG_SYNC_IGN_VAL); // R14

   // registered outputs; downstream stages treat the pattern as data
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out         <= SLPTG_REG_RESET;
         reg_rvalid_out        <= 1'b0;
         tpl_data_out          <= SLPTG_ZERO_W;
         tpl_sel_out           <= 1'b0;
         phy_data_out          <= 10'h000;
         phy_sel_out           <= 1'b0;
         scr_data_out          <= 8'h00;
         scr_sel_out           <= 1'b0;
         pre_bypass_out        <= 1'b0;
         dll_test_sel_out      <= 3'h0;
         link_sync_request_out <= 1'b0;
      end else begin
         reg_rdata_out         <= reg_rd_in ? rd_mux : SLPTG_REG_RESET;
         reg_rvalid_out        <= reg_rd_in;
         tpl_data_out          <= tpl_d;
         tpl_sel_out           <= tpl_pat || tpl_test; // R4
         phy_data_out          <= phy_pat;
         phy_sel_out           <= phy_pat_on; // R15
         scr_data_out          <= scr_pat;
         scr_sel_out           <= scr_pat_on; // R15
         pre_bypass_out        <= active; // R15
         dll_test_sel_out      <= link_layer_test_select_q[2:0]; // R13
         link_sync_request_out <= link_sync_request_input_in && !sync_ign; // R14
      end
   end
endmodule
`default_nettype wire

/* sim/slptg_chk.sv */
// port checker of the test pattern generator
`timescale 1ns/10ps
`default_nettype none
module slptg_chk (
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [7:0]  reg_wdata_in,
   input wire logic [7:0]  reg_rdata_out,
   input wire logic        reg_rvalid_out,
   input wire logic [15:0] sample_in,
   input wire logic        unit_adv_in,
   input wire logic        link_sync_request_input_in,
   input wire logic [15:0] tpl_data_out,
   input wire logic [9:0]  phy_data_out,
   input wire logic        phy_sel_out,
   input wire logic [7:0]  scr_data_out,
   input wire logic        scr_sel_out,
   input wire logic        pre_bypass_out,
   input wire logic [2:0]  dll_test_sel_out,
   input wire logic        link_sync_request_out
);
   // ==========================================================
   // one clock and one reset for every property
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   // ==========================================================
   // steps: a read, three quiet cycles, a link test select write
   sequence s_read;
      reg_rd_in;
   endsequence
   sequence s_quiet;
      (!unit_adv_in && !reg_wr_in) [*3];
   endsequence
   sequence s_dll_write;
      reg_wr_in && (reg_addr_in == 12'h0574);
   endsequence
   // ==========================================================
   // assertions
   read_answer_a: assert property (s_read |=> reg_rvalid_out)
      else $error("read strobe got no answer one cycle later");
   answer_cause_a: assert property (reg_rvalid_out |-> $past(reg_rd_in))
      else $error("read answer without a read strobe");
   idle_rdata_a: assert property (!reg_rvalid_out |-> reg_rdata_out == 8'h00)
      else $error("read data not zero outside an answer");
   normal_path_a: assert property (!pre_bypass_out |-> tpl_data_out == $past(sample_in))
      else $error("sample path does not carry the delayed sample");
   one_point_a: assert property (!(phy_sel_out && scr_sel_out))
      else $error("two injection points selected at once");
   point_bypass_a: assert property ((phy_sel_out || scr_sel_out) |-> pre_bypass_out)
      else $error("test injected without bypass of earlier stages");
   word_hold_a: assert property (s_quiet ##0 pre_bypass_out |=> $stable({phy_data_out, scr_data_out}))
      else $error("pattern word moved without an advance");
   dll_copy_a: assert property (s_dll_write |-> ##2 dll_test_sel_out == $past(reg_wdata_in[2:0], 2))
      else $error("link test select does not follow its register");
   sync_gate_a: assert property (link_sync_request_out |-> $past(link_sync_request_input_in))
      else $error("sync request out without sync request in");
endmodule
`default_nettype wire

/* sim/slptg_rx_model.sv */
// behavioural link receiver: raises its sync request and keeps the last lane symbol
`timescale 1ns/10ps
`default_nettype none
module slptg_rx_model (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   input  wire logic       sync_want_in,
   input  wire logic [9:0] phy_data_in,
   output logic            sync_req_out,
   output logic      [9:0] last_word_out
);
   // request is registered like a real receiver would, so it lags one clock
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_req_out  <= 1'b0;
         last_word_out <= 10'h000;
      end else begin
         sync_req_out  <= sync_want_in;
         last_word_out <= phy_data_in;
      end
   end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the test pattern generator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import slptg_pkg::*;
   logic        clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out, unit_adv_in, sync_want;
   logic        link_sync_request_input_in, tpl_sel_out, phy_sel_out, scr_sel_out, pre_bypass_out;
   logic        link_sync_request_out;
   logic [11:0] reg_addr_in;
   logic [7:0]  reg_wdata_in, reg_rdata_out, scr_data_out;
   logic [15:0] sample_in, tpl_data_out;
   logic [9:0]  phy_data_out;
   logic [2:0]  dll_test_sel_out;
   logic [15:0] up [4];
   logic [7:0]  rq [$];
   logic [3:0]  codes [5] = '{4'h1, 4'h2, 4'h8, 4'hE, 4'hF};
   int          num_errors, n_checks, cyc, seed;
   // ==========================================================
   // design and far-end receiver
   slptg_top DUT (.clk_sys_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
      .reg_rdata_out, .reg_rvalid_out, .sample_in, .unit_adv_in, .link_sync_request_input_in,
      .tpl_data_out, .tpl_sel_out, .phy_data_out, .phy_sel_out, .scr_data_out, .scr_sel_out,
      .pre_bypass_out, .dll_test_sel_out, .link_sync_request_out);
   slptg_rx_model u_rx (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sync_want_in(sync_want),
      .phy_data_in(phy_data_out), .sync_req_out(link_sync_request_input_in), .last_word_out());
   // ==========================================================
   // helpers: compare, register cycles, waits, expected words
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk_sys_in);
      rq.push_back(exp);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   // soft reset, fresh random user words, then start the chosen test
   task automatic cfg(input logic [7:0] sel);
      wr(SLPTG_ADDR_SOFT_RST, 8'h81);
      for (int i = 0; i < 4; i++) begin
         up[i] = 16'($urandom);
         wr(SLPTG_ADDR_UP_FIRST + 12'(2 * i), up[i][7:0]);
         wr(SLPTG_ADDR_UP_FIRST + 12'(2 * i + 1), up[i][15:8]);
      end
      wr(SLPTG_ADDR_ITS_SEL, sel);
      tk(4);
   endtask
   function automatic logic [15:0] expv(input logic [3:0] c, input int inj, input int k);
      logic [15:0] w;
      case (c)
         4'h1: w = k[0] ? 16'hAAAA : 16'h5555;
         4'h2: w = k[0] ? 16'hFFFF : 16'h0000;
         4'h8: w = 16'(k);
         4'hE: w = up[k % 4];
         default: w = (k < 4) ? up[k] : 16'h0000;
      endcase
      if (c == 4'h8) return (inj == 0) ? w : ((inj == 1) ? {6'h00, w[9:0]} : {8'h00, w[7:0]});
      if (inj == 1) return {6'h00, w[15:6]};
      if (inj == 2) return {8'h00, (c >= 4'hE) ? {1'b0, w[15:9]} : w[15:8]};
      return w;
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==========================================================
   // clock, read answer watcher, hang limit
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   always @(negedge clk_sys_in) begin
      if (reg_rvalid_out === 1'b1) chk("read data", {8'h00, reg_rdata_out}, {8'h00, rq.pop_front()});
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         $display("run took too long");
         stop_test();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      {rst_n_in, reg_wr_in, reg_rd_in, unit_adv_in, sync_want} = 5'h00;
      {reg_addr_in, reg_wdata_in, sample_in} = 36'h0_0000_0000;
      seed = $urandom(25494);
      repeat (10) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      for (int i = 1; i < 5; i++) rd(12'h0570 + 12'(i), 8'h00);
      wr(12'h0100, 8'hFF);
      rd(12'h0100, 8'h00);
      $display("test reset values done");
      for (int j = 0; j < 3; j++) begin
         for (int c = 0; c < 5; c++) begin
            cfg({2'b00, 2'(j), codes[c]});
            for (int k = 0; k < 6; k++) begin
               repeat (2) begin
                  chk("pattern", (j == 0) ? tpl_data_out : ((j == 1) ? {6'h00, phy_data_out} :
                     {8'h00, scr_data_out}), expv(codes[c], j, k));
                  chk("selects", {12'h000, tpl_sel_out, phy_sel_out, scr_sel_out, pre_bypass_out},
                     {12'h000, 3'b100 >> j, 1'b1});
                  tk(1);
               end
               @(posedge clk_sys_in);
               unit_adv_in <= 1'b1;
               sample_in   <= 16'($urandom);
               @(posedge clk_sys_in);
               unit_adv_in <= 1'b0;
               tk(3);
            end
         end
         $display("test injection point %0d done", j);
      end
      for (int i = 0; i < 8; i++) rd(SLPTG_ADDR_UP_FIRST + 12'(i), i[0] ? up[i / 2][15:8] : up[i / 2][7:0]);
      wr(SLPTG_ADDR_ITS_SEL, 8'h00);
      tk(3);
      chk("bypass after code zero", {15'h0000, pre_bypass_out}, 16'h0001);
      rd(SLPTG_ADDR_ITS_SEL, 8'h00);
      wr(SLPTG_ADDR_SOFT_RST, 8'h81);
      tk(3);
      chk("bypass after soft reset", {15'h0000, pre_bypass_out}, 16'h0000);
      rd(SLPTG_ADDR_SOFT_RST, 8'h00);
      rd(SLPTG_ADDR_UP_FIRST, 8'h00);
      $display("test soft reset done");
      for (int c = 3; c < 8; c++) begin
         cfg({4'h1, 4'(c)});
         chk("pn selects", {12'h000, tpl_sel_out, phy_sel_out, scr_sel_out, pre_bypass_out}, 16'h0005);
         if (c == 4 || c == 6) chk("pn word 0", {6'h00, phy_data_out}, (c == 4) ? 16'h03FD : 16'h0125);
         @(posedge clk_sys_in);
         unit_adv_in <= 1'b1;
         @(posedge clk_sys_in);
         unit_adv_in <= 1'b0;
         tk(3);
         if (c == 4 || c == 6) chk("pn word 1", {6'h00, phy_data_out}, (c == 4) ? 16'h01C0 : 16'h02FC);
      end
      cfg(8'h09);
      chk("unused code", tpl_data_out, 16'h0000);
      wr(SLPTG_ADDR_SOFT_RST, 8'h81);
      wr(SLPTG_ADDR_TPL_TEST, 8'h20);
      rd(SLPTG_ADDR_TPL_TEST, 8'h20);
      repeat (4) begin
         @(posedge clk_sys_in);
         sample_in <= 16'($urandom);
         tk(1);
         chk("raw sample", tpl_data_out, sample_in);
         chk("sample select", {15'h0000, tpl_sel_out}, 16'h0001);
      end
      wr(SLPTG_ADDR_TPL_TEST, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(SLPTG_ADDR_DLL_SEL, 8'(i));
         tk(3);
         chk("link test select", {13'h0000, dll_test_sel_out}, 16'(i));
      end
      $display("test sample and link tests done");
      wr(SLPTG_ADDR_SYNC_CTL, 8'hC0);
      sync_want <= 1'b1;
      tk(4);
      chk("masked sync", {15'h0000, link_sync_request_out}, 16'h0000);
      rd(SLPTG_ADDR_SYNC_CTL, 8'hC0);
      wr(SLPTG_ADDR_SYNC_CTL, 8'h00);
      tk(3);
      chk("passed sync", {15'h0000, link_sync_request_out}, 16'h0001);
      $display("test sync masking done");
      tk(3);
      stop_test();
   end
endmodule
bind slptg_top slptg_chk u_chk (.clk_sys_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
   .reg_rdata_out, .reg_rvalid_out, .sample_in, .unit_adv_in, .link_sync_request_input_in, .tpl_data_out,
   .phy_data_out, .phy_sel_out, .scr_data_out, .scr_sel_out, .pre_bypass_out, .dll_test_sel_out,
   .link_sync_request_out);
`default_nettype wire
